// ==== core/txs_exec.sv ====
// Operation
// - Table write decodes with two-bit pointer mode
// - Pointer is a 21-bit byte address
// - Pointer bit 0 picks low/high word byte
// - Low pointer bits pick one of eight holders
// - Table write only loads a holding register
// - Table write: two cycles, Q2 read, Q4 write
// - Table read: Q2 memory read, Q4 latch
// - Pointer keep, post-inc, post-dec, pre-inc
// - Test-skip takes file and bank bit, no flags
// - Zero result discards next instruction, one NOP; code runs two NOP cycles when the next instruction is two-word
// - Xor literal: accumulator xor literal into accumulator
// - Xor updates only negative and zero flags
// - Xor file: decode, read, process, write quarters
// - Table read decodes with same mode field
// - Access bit 0 forces fixed access bank
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module txs_exec #(
	parameter int unsigned QDIV = txs_pkg::QUARTER_DIV
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic      [19:0] pmem_word_addr_out,
	output logic             pmem_rd_out,
	input  wire logic [15:0] pmem_data_in,
	output logic      [11:0] file_addr_out,
	output logic             file_rd_out,
	input  wire logic [7:0]  file_rdata_in,
	output logic             file_we_out,
	output logic      [7:0]  file_wdata_out,
	output logic      [63:0] hold_data_out,
	output logic             busy_out
);

	// ****************************************************************
	// Reset release and quarter phases
	// ****************************************************************
	logic [1:0] rst_sync_q;
	logic       rst_n;
	logic       q_tick;
	logic [1:0] q_idx;

	// Two-stage release; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	txs_qphase #(
		.DIV (QDIV)
	) u_qphase (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n),
		.q_tick_out (q_tick),
		.q_idx_out  (q_idx)
	);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic txs_pkg::txs_op_t decode_op(input logic [15:0] w);
		if ((w & txs_pkg::TBL_MASK) == txs_pkg::TABLE_READ_OP_PAT)
			return txs_pkg::TXS_OP_TABLE_READ_OP;
		if ((w & txs_pkg::TBL_MASK) == txs_pkg::TABLE_WRITE_OP_PAT)
			return txs_pkg::TXS_OP_TABLE_WRITE_OP;
		if (w[15:8] == txs_pkg::XORL_PAT)
			return txs_pkg::TXS_OP_XORL;
		if (w[15:10] == txs_pkg::XORF_PAT)
			return txs_pkg::TXS_OP_XORF;
		if (w[15:9] == txs_pkg::TST_PAT)
			return txs_pkg::TXS_OP_TST;
		return txs_pkg::TXS_OP_NONE;
	endfunction

	// Bank resolution for file operands
	function automatic logic [11:0] bank_addr(input logic a,
		input logic [7:0] f, input logic [3:0] bank_select_register);
		if (a)
			return {bank_select_register, f};
		if (f < txs_pkg::ACC_SPLIT)
			return {txs_pkg::ACC_LO_BANK, f};
		return {txs_pkg::ACC_HI_BANK, f};
	endfunction

	// ****************************************************************
	// State and registers
	// ****************************************************************
	txs_pkg::txs_state_t state_q;
	txs_pkg::txs_op_t    op_q;
	logic [20:0] ptr_q;
	logic [7:0]  lat_q;
	logic [7:0]  acc_q;
	logic [7:0]  stat_q;
	logic [3:0]  bank_q;
	logic [16:0] instr_q;
	logic [7:0]  operand_q;
	logic [7:0]  result_q;
	logic [7:0]  byte_q;
	logic [11:0] faddr_q;
	logic        zero_q;
	logic [31:0] prdata_q;
	logic [1:0]  mode;
	logic        dest_file;
	logic        q4_end;
	logic        cyc1_end;
	logic        cyc2_end;
	logic        table_op;
	logic        hold_we;
	logic        setup;
	logic        access;
	logic        mapped;
	logic        hold_sel;
	logic        accept;
	logic        wr_ok;
	logic        wr_take;

	assign mode      = instr_q[1:0];
	assign dest_file = instr_q[txs_pkg::DEST_BIT];
	assign q4_end    = q_tick && (q_idx == txs_pkg::QP4);
	assign cyc1_end  = q4_end && (state_q == txs_pkg::TXS_CYC1);
	assign cyc2_end  = q4_end && (state_q == txs_pkg::TXS_CYC2);
	assign table_op  = (op_q == txs_pkg::TXS_OP_TABLE_READ_OP)
		|| (op_q == txs_pkg::TXS_OP_TABLE_WRITE_OP);
	assign busy_out  = (state_q != txs_pkg::TXS_IDLE);

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign setup    = psel_in && !penable_in;
	assign access   = psel_in && penable_in;
	assign hold_sel = (paddr_in[7:5] == txs_pkg::OFF_HOLD_HI)
		&& (paddr_in[1:0] == 2'h0);
	assign mapped   = hold_sel
		|| (paddr_in == txs_pkg::OFF_PTR) || (paddr_in == txs_pkg::OFF_LAT)
		|| (paddr_in == txs_pkg::OFF_ACC) || (paddr_in == txs_pkg::OFF_STAT)
		|| (paddr_in == txs_pkg::OFF_BANK) || (paddr_in == txs_pkg::OFF_INSTR)
		|| (paddr_in == txs_pkg::OFF_EXEC);

	// Instructions start only at a cycle boundary so Q1 lines up
	assign accept = access && pwrite_in && (paddr_in == txs_pkg::OFF_INSTR)
		&& !busy_out && q4_end;
	// Writes wait while executing so hardware and software never collide
	assign wr_ok = (paddr_in == txs_pkg::OFF_INSTR) ? accept : !busy_out;
	assign pready_out  = !(access && pwrite_in && mapped) || wr_ok;
	assign pslverr_out = access && !mapped;
	assign wr_take = access && pwrite_in && mapped && wr_ok;
	assign prdata_out  = prdata_q;

	// Read data captured in the setup cycle
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			prdata_q <= 32'h00000000;
		else if (setup && !pwrite_in)
		begin
			prdata_q <= 32'h00000000;
			if (hold_sel)
				prdata_q[7:0] <= hold_data_out[paddr_in[4:2]*8 +: 8];
			else
				unique case (paddr_in)
					txs_pkg::OFF_PTR:   prdata_q[20:0] <= ptr_q;
					txs_pkg::OFF_LAT:   prdata_q[7:0]  <= lat_q;
					txs_pkg::OFF_ACC:   prdata_q[7:0]  <= acc_q;
					txs_pkg::OFF_STAT:  prdata_q[7:0]  <= stat_q;
					txs_pkg::OFF_BANK:  prdata_q[3:0]  <= bank_q;
					txs_pkg::OFF_INSTR: prdata_q[16:0] <= instr_q;
					txs_pkg::OFF_EXEC:  prdata_q[1:0]  <= {zero_q, busy_out};
					default:            prdata_q <= 32'h00000000;
				endcase
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= txs_pkg::TXS_IDLE;
		else if (accept)
			state_q <= txs_pkg::TXS_CYC1;
		else if (q4_end)
			unique case (state_q)
				txs_pkg::TXS_IDLE:  state_q <= txs_pkg::TXS_IDLE;
				txs_pkg::TXS_CYC1:
					if (table_op)
						state_q <= txs_pkg::TXS_CYC2;
					else if (op_q == txs_pkg::TXS_OP_TST && zero_q)
						state_q <= txs_pkg::TXS_SKIP1;
					else
						state_q <= txs_pkg::TXS_IDLE;
				txs_pkg::TXS_CYC2:  state_q <= txs_pkg::TXS_IDLE;
				txs_pkg::TXS_SKIP1:
					state_q <= instr_q[txs_pkg::TWO_WORD_BIT]
						? txs_pkg::TXS_SKIP2 : txs_pkg::TXS_IDLE;
				txs_pkg::TXS_SKIP2: state_q <= txs_pkg::TXS_IDLE;
			endcase
	end

	// Q1 decode: opcode, operand address and literal captured on accept
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instr_q <= 17'h00000;
			op_q    <= txs_pkg::TXS_OP_NONE;
			faddr_q <= 12'h000;
		end
		else if (accept)
		begin
			instr_q <= pwdata_in[16:0];
			op_q    <= decode_op(pwdata_in[15:0]);
			faddr_q <= bank_addr(pwdata_in[txs_pkg::ABIT], pwdata_in[7:0],
				bank_q);
		end
	end

	// Q2 file read and Q3 processing
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			operand_q <= 8'h00;
			result_q  <= 8'h00;
			zero_q    <= 1'b0;
		end
		else if (accept)
			operand_q <= pwdata_in[7:0];
		else if (q_tick && state_q == txs_pkg::TXS_CYC1)
		begin
			if (q_idx == txs_pkg::QP2 && file_rd_out)
				operand_q <= file_rdata_in;
			if (q_idx == txs_pkg::QP3)
			begin
				result_q <= acc_q ^ operand_q;
				zero_q   <= (operand_q == 8'h00);
			end
		end
	end

	assign file_rd_out = (state_q == txs_pkg::TXS_CYC1)
		&& (q_idx == txs_pkg::QP2) && ((op_q == txs_pkg::TXS_OP_XORF)
		|| (op_q == txs_pkg::TXS_OP_TST));
	assign file_addr_out  = faddr_q;
	assign file_wdata_out = result_q;
	assign file_we_out = cyc1_end && (op_q == txs_pkg::TXS_OP_XORF)
		&& dest_file;

	// Q4 accumulator and flags; software writes only when idle
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_q  <= txs_pkg::DAT_RST;
			stat_q <= txs_pkg::DAT_RST;
		end
		else if (cyc1_end && (op_q == txs_pkg::TXS_OP_XORL
			|| op_q == txs_pkg::TXS_OP_XORF))
		begin
			if (op_q == txs_pkg::TXS_OP_XORL || !dest_file)
				acc_q <= result_q;
			stat_q[txs_pkg::ST_Z] <= (result_q == 8'h00);
			stat_q[txs_pkg::ST_N] <= result_q[7];
		end
		else if (wr_take && paddr_in == txs_pkg::OFF_ACC)
			acc_q <= pwdata_in[7:0];
		else if (wr_take && paddr_in == txs_pkg::OFF_STAT)
			stat_q <= {3'h0, pwdata_in[4:0]};
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			bank_q <= txs_pkg::BANK_RST;
		else if (wr_take && paddr_in == txs_pkg::OFF_BANK)
			bank_q <= pwdata_in[3:0];
	end

	// ****************************************************************
	// Table pointer, latch and holding registers
	// ****************************************************************
	// Word address plus byte lane; bit 0 set is the high byte
	assign pmem_word_addr_out = ptr_q[20:1];
	assign pmem_rd_out = (state_q == txs_pkg::TXS_CYC2)
		&& (q_idx == txs_pkg::QP2) && (op_q == txs_pkg::TXS_OP_TABLE_READ_OP);

	// Q2 of the second cycle fetches the byte or reads the latch
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			byte_q <= 8'h00;
		else if (q_tick && q_idx == txs_pkg::QP2
			&& state_q == txs_pkg::TXS_CYC2)
		begin
			if (op_q == txs_pkg::TXS_OP_TABLE_READ_OP)
				byte_q <= ptr_q[0] ? pmem_data_in[15:8]
					: pmem_data_in[7:0];
			else
				byte_q <= lat_q;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			lat_q <= txs_pkg::DAT_RST;
		else if (cyc2_end && op_q == txs_pkg::TXS_OP_TABLE_READ_OP)
			lat_q <= byte_q;
		else if (wr_take && paddr_in == txs_pkg::OFF_LAT)
			lat_q <= pwdata_in[7:0];
	end

	// Pre-increment lands before the transfer, post moves after it
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			ptr_q <= txs_pkg::PTR_RST;
		else if (cyc1_end && table_op && mode == txs_pkg::MODE_PREINC)
			ptr_q <= ptr_q + txs_pkg::PTR_ONE;
		else if (cyc2_end && mode == txs_pkg::MODE_POSTINC)
			ptr_q <= ptr_q + txs_pkg::PTR_ONE;
		else if (cyc2_end && mode == txs_pkg::MODE_POSTDEC)
			ptr_q <= ptr_q - txs_pkg::PTR_ONE;
		else if (wr_take && paddr_in == txs_pkg::OFF_PTR)
			ptr_q <= pwdata_in[20:0];
	end

	// Only stages a byte; programming the array is done elsewhere
	assign hold_we = cyc2_end && (op_q == txs_pkg::TXS_OP_TABLE_WRITE_OP);

	txs_hold #(
		.N (txs_pkg::HOLD_N),
		.W (txs_pkg::DAT_W)
	) u_hold (
		.clk_in   (clk_in),
		.rst_n_in (rst_n),
		.we_in    (hold_we),
		.idx_in   (ptr_q[2:0]),
		.data_in  (byte_q),
		.flat_out (hold_data_out)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	a_hold_index_data: assert property (hold_we |=>
		hold_data_out[$past(ptr_q[2:0])*8 +: 8] == $past(lat_q))
		else $error("holding byte not written from latch");
	a_tw_q4_timing: assert property (hold_we |->
		state_q == txs_pkg::TXS_CYC2 && q_idx == txs_pkg::QP4)
		else $error("holding write outside second cycle Q4");
	a_rd_latch_load: assert property (cyc2_end
		&& op_q == txs_pkg::TXS_OP_TABLE_READ_OP |=> lat_q == $past(byte_q))
		else $error("latch not loaded at table read end");
	a_ptr_post_inc: assert property (cyc2_end
		&& mode == txs_pkg::MODE_POSTINC |=> ptr_q == $past(ptr_q) + 21'h1)
		else $error("post increment wrong");
	a_ptr_post_dec: assert property (cyc2_end
		&& mode == txs_pkg::MODE_POSTDEC |=> ptr_q == $past(ptr_q) - 21'h1)
		else $error("post decrement wrong");
	a_tst_no_flags: assert property (cyc1_end
		&& op_q == txs_pkg::TXS_OP_TST |=> $stable(stat_q))
		else $error("test changed status");
	a_skip_one_nop: assert property (cyc1_end && op_q == txs_pkg::TXS_OP_TST
		&& zero_q && !instr_q[txs_pkg::TWO_WORD_BIT] |=>
		state_q == txs_pkg::TXS_SKIP1 ##1
		(state_q == txs_pkg::TXS_SKIP1)[*3] ##1 !busy_out)
		else $error("single skip not one cycle");
	a_skip_two_nop: assert property (q4_end && state_q == txs_pkg::TXS_SKIP1
		&& instr_q[txs_pkg::TWO_WORD_BIT] |=> state_q == txs_pkg::TXS_SKIP2)
		else $error("two word skip missed second cycle");
	a_xor_lit_acc: assert property (cyc1_end && op_q == txs_pkg::TXS_OP_XORL
		|=> acc_q == ($past(acc_q) ^ $past(operand_q)))
		else $error("xor literal result wrong");
	a_xor_flag_keep: assert property (
		cyc1_end && (op_q == txs_pkg::TXS_OP_XORL
		|| op_q == txs_pkg::TXS_OP_XORF) |=> stat_q == {$past(stat_q[7:5]),
		$past(result_q[7]), $past(stat_q[3]), $past(result_q) == 8'h00,
		$past(stat_q[1:0])})
		else $error("xor touched other flags");
	a_file_rd_q2: assert property (file_rd_out |-> state_q
		== txs_pkg::TXS_CYC1 && q_idx == txs_pkg::QP2)
		else $error("file read outside Q2");
	a_nonzero_done: assert property (cyc1_end && op_q == txs_pkg::TXS_OP_TST
		&& !zero_q |=> !busy_out)
		else $error("nonzero test did not finish");

endmodule
`default_nettype wire

// ==== core/txs_hold.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Holding registers staged for later programming
// ****************************************************************
module txs_hold #(
	parameter int unsigned N = txs_pkg::HOLD_N,
	parameter int unsigned W = txs_pkg::DAT_W
) (
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic                 we_in,
	input  wire logic [$clog2(N)-1:0] idx_in,
	input  wire logic [W-1:0]         data_in,
	output logic      [N*W-1:0]       flat_out
);

	// One byte per entry, erased value after reset
	for (genvar i = 0; i < N; i++)
	begin : g_ent
		always_ff @(posedge clk_in or negedge rst_n_in)
		begin
			if (!rst_n_in)
				flat_out[i*W +: W] <= W'(txs_pkg::HOLD_RST);
			else if (we_in && (idx_in == i))
				flat_out[i*W +: W] <= data_in;
		end
	end

endmodule
`default_nettype wire

// ==== core/txs_pkg.sv ====
// ****************************************************************
// Shared constants for the table, xor and skip execution block
// ****************************************************************
package txs_pkg;

	// Widths and counts
	localparam int unsigned PTR_W      = 21;
	localparam int unsigned DAT_W      = 8;
	localparam int unsigned HOLD_N     = 8;
	localparam int unsigned HOLD_IDX_W = 3;
	localparam int unsigned FADDR_W    = 12;
	localparam int unsigned BANK_W     = 4;
	localparam int unsigned QUARTER_DIV = 1;  // Clocks per quarter phase

	// Quarter phases of one instruction cycle
	localparam logic [1:0] QP1 = 2'h0;
	localparam logic [1:0] QP2 = 2'h1;
	localparam logic [1:0] QP3 = 2'h2;
	localparam logic [1:0] QP4 = 2'h3;

	// Opcode patterns
	localparam logic [15:0] TBL_MASK  = 16'hFFFC;
	localparam logic [15:0] TABLE_READ_OP_PAT = 16'h0008;
	localparam logic [15:0] TABLE_WRITE_OP_PAT = 16'h000C;
	localparam logic [7:0]  XORL_PAT  = 8'h0A;
	localparam logic [5:0]  XORF_PAT  = 6'h06;
	localparam logic [6:0]  TST_PAT   = 7'h33;

	// Field positions in the instruction register
	localparam int unsigned DEST_BIT     = 9;
	localparam int unsigned ABIT         = 8;
	localparam int unsigned TWO_WORD_BIT = 16;

	// Pointer modes
	localparam logic [1:0] MODE_KEEP    = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_POSTDEC = 2'h2;
	localparam logic [1:0] MODE_PREINC  = 2'h3;
	localparam logic [20:0] PTR_ONE     = 21'h000001;

	// Fixed access bank split
	localparam logic [7:0] ACC_SPLIT   = 8'h80;
	localparam logic [3:0] ACC_LO_BANK = 4'h0;
	localparam logic [3:0] ACC_HI_BANK = 4'hF;

	// Status bit positions
	localparam int unsigned ST_C  = 0;
	localparam int unsigned ST_DC = 1;
	localparam int unsigned ST_Z  = 2;
	localparam int unsigned ST_OV = 3;
	localparam int unsigned ST_N  = 4;

	// Register byte offsets
	localparam logic [7:0] OFF_PTR   = 8'h00;
	localparam logic [7:0] OFF_LAT   = 8'h04;
	localparam logic [7:0] OFF_ACC   = 8'h08;
	localparam logic [7:0] OFF_STAT  = 8'h0C;
	localparam logic [7:0] OFF_BANK  = 8'h10;
	localparam logic [7:0] OFF_INSTR = 8'h14;
	localparam logic [7:0] OFF_EXEC  = 8'h18;
	localparam logic [2:0] OFF_HOLD_HI = 3'h1;  // 0x20..0x3C

	// Reset values
	localparam logic [20:0] PTR_RST  = 21'h000000;
	localparam logic [7:0]  DAT_RST  = 8'h00;
	localparam logic [7:0]  HOLD_RST = 8'hFF;
	localparam logic [3:0]  BANK_RST = 4'h0;

	typedef enum logic [2:0] {
		TXS_OP_NONE,
		TXS_OP_TABLE_READ_OP,
		TXS_OP_TABLE_WRITE_OP,
		TXS_OP_XORL,
		TXS_OP_XORF,
		TXS_OP_TST
	} txs_op_t;

	typedef enum logic [2:0] {
		TXS_IDLE,
		TXS_CYC1,
		TXS_CYC2,
		TXS_SKIP1,
		TXS_SKIP2
	} txs_state_t;

endpackage

// ==== core/txs_qphase.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Quarter phase divider
// ****************************************************************
module txs_qphase #(
	parameter int unsigned DIV = txs_pkg::QUARTER_DIV
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	output logic            q_tick_out,
	output logic [1:0]      q_idx_out
);

	logic [7:0] div_q;

	// Tick marks the last clock of each quarter
	assign q_tick_out = (div_q == 8'(DIV - 1));

	// Divider; DIV of one makes every clock a quarter
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			div_q <= 8'h00;
		else if (q_tick_out)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// Phase index wraps Q4 back to Q1
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			q_idx_out <= txs_pkg::QP1;
		else if (q_tick_out)
			q_idx_out <= q_idx_out + 2'h1;
	end

endmodule
`default_nettype wire

// ==== tb/table_xor_skip_exec_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Testbench
// ****************************************************************
module table_xor_skip_exec_tb;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready, pslverr, pmem_rd, frd, fwe, busy;
	logic [19:0] pmem_addr;
	logic [15:0] pmem_data;
	logic [11:0] faddr;
	logic [7:0]  frdata, fwdata;
	logic [63:0] hold;
	logic [63:0] hexp = 64'hFFFFFFFFFFFFFFFF;
	int          miscompares = 0;
	int          cmp_count = 0;

	txs_exec i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .pmem_word_addr_out(pmem_addr),
		.pmem_rd_out(pmem_rd), .pmem_data_in(pmem_data),
		.file_addr_out(faddr), .file_rd_out(frd), .file_rdata_in(frdata),
		.file_we_out(fwe), .file_wdata_out(fwdata), .hold_data_out(hold),
		.busy_out(busy));
	txs_mem_model i_mem (.clk_in(clk_in), .pmem_word_addr_in(pmem_addr),
		.pmem_rd_in(pmem_rd), .pmem_data_out(pmem_data),
		.file_addr_in(faddr), .file_rd_in(frd), .file_we_in(fwe),
		.file_wdata_in(fwdata), .file_rdata_out(frdata));

	initial
	begin
		forever #2 clk_in = ~clk_in;
	end

	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		@(posedge clk_in);
		while (pready !== 1'b1)
			@(posedge clk_in);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic chk(input string n, input logic [63:0] x, g);
		cmp_count++;
		if (g !== x)
		begin
			$display("wrong value %s expected %h seen %h", n, x, g);
			miscompares++;
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(n, {32'h00000000, x}, {32'h00000000, r});
	endtask
	// Issue one instruction and count the clocks that busy stays high
	task automatic run(input logic [16:0] ins, output int c);
		wr(8'h14, {15'h0000, ins});
		c = 0;
		@(posedge clk_in);
		while (busy === 1'b1 && c < 64)
		begin
			c++;
			@(posedge clk_in);
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		rchk("pointer", 8'h00, 32'h00000000);
		rchk("hold reg", 8'h3C, 32'h000000FF);
		chk("hold bus", 64'hFFFFFFFFFFFFFFFF, hold);
		apb(1'b0, 8'h1C, 32'h00000000, r, e);
		chk("unmapped data", 64'h0, {32'h00000000, r});
		chk("unmapped err", 64'h1, {63'h0, e});
		$display("test reset done");
	endtask
	// Flags preset so that untouched bits stay visibly set
	task automatic t_xorl;
		logic [7:0] ac[3] = '{8'hB5, 8'h5A, 8'h0F};
		logic [7:0] k[3] = '{8'hAF, 8'h5A, 8'hF0};
		logic [4:0] st[3] = '{5'h0F, 5'h1B, 5'h0F};
		logic [7:0] r;
		int         c;
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h08, {24'h000000, ac[i]});
			wr(8'h0C, {27'h0000000, st[i]});
			run({9'h00A, k[i]}, c);
			r = ac[i] ^ k[i];
			rchk("acc", 8'h08, {24'h000000, r});
			rchk("status", 8'h0C, {27'h0, r[7], st[i][3], r == 8'h00,
				st[i][1:0]});
		end
		$display("test xor literal done");
	endtask
	task automatic t_xorf;
		logic [3:0]  b[3] = '{4'h5, 4'h3, 4'h3};
		logic [7:0]  f[3] = '{8'h20, 8'h90, 8'h10};
		logic        a[3] = '{1'b1, 1'b0, 1'b0};
		logic        d[3] = '{1'b1, 1'b0, 1'b1};
		logic [7:0]  fv[3] = '{8'hAF, 8'h33, 8'h80};
		logic [7:0]  ac[3] = '{8'hB5, 8'h33, 8'h00};
		logic [11:0] ea;
		logic [7:0]  r;
		int          c;
		for (int i = 0; i < 3; i++)
		begin
			ea = a[i] ? {b[i], f[i]} : {f[i][7] ? 4'hF : 4'h0, f[i]};
			i_mem.fmem[ea] = fv[i];
			wr(8'h10, {28'h0000000, b[i]});
			wr(8'h08, {24'h000000, ac[i]});
			wr(8'h0C, 32'h0000000B);
			run({7'h06, d[i], a[i], f[i]}, c);
			r = fv[i] ^ ac[i];
			chk("xor cycles", 64'h4, 64'(c));
			chk("file", {56'h0, d[i] ? r : fv[i]}, {56'h0, i_mem.fmem[ea]});
			rchk("acc", 8'h08, {24'h000000, d[i] ? ac[i] : r});
			rchk("status", 8'h0C, {27'h0, r[7], 1'b1, r == 8'h00,
				2'h3});
		end
		$display("test xor file done");
	endtask
	task automatic t_tst;
		logic [7:0] f[3] = '{8'h40, 8'h41, 8'hC0};
		logic       a[3] = '{1'b0, 1'b1, 1'b0};
		logic       two[3] = '{1'b0, 1'b1, 1'b0};
		logic [7:0] fv[3] = '{8'h00, 8'h00, 8'h01};
		int         n[3] = '{8, 12, 4};
		int         c;
		i_mem.fmem[12'h040] = 8'h55;
		wr(8'h10, 32'h00000003);
		wr(8'h0C, 32'h00000015);
		for (int i = 0; i < 3; i++)
		begin
			i_mem.fmem[{a[i] ? 4'h3 : (f[i][7] ? 4'hF : 4'h0), f[i]}] = fv[i];
			run({two[i], 7'h33, a[i], f[i]}, c);
			chk("skip cycles", 64'(n[i]), 64'(c));
			rchk("zero flag", 8'h18, {30'h0, fv[i] == 8'h00, 1'b0});
			rchk("status", 8'h0C, 32'h00000015);
		end
		$display("test skip done");
	endtask
	// Mid-range pointers tell index bits apart; pre-increment wraps to zero
	task automatic t_tbl(input logic w);
		logic [20:0] p;
		logic [20:0] ea;
		logic [20:0] np;
		logic [7:0]  lat;
		int          c;
		for (int m = 0; m < 4; m++)
		begin
			p = (m == 3) ? 21'h1FFFFF : 21'h00A356 + 21'(m);
			lat = 8'h40 + 8'(m);
			wr(8'h00, {11'h000, p});
			wr(8'h04, {24'h000000, lat});
			run({14'h0001, w, 2'(m)}, c);
			ea = (m == 3) ? p + 21'h000001 : p;
			np = (m == 2) ? p - 21'h000001 : (m == 0 ? p : p + 21'h000001);
			chk("table cycles", 64'h8, 64'(c));
			rchk("pointer", 8'h00, {11'h000, np});
			if (w)
			begin
				hexp[8 * ea[2:0] +: 8] = lat;
				chk("hold bus", hexp, hold);
				rchk("hold reg", {3'h1, ea[2:0], 2'h0}, {24'h0, lat});
				rchk("latch", 8'h04, {24'h000000, lat});
			end
			else
				rchk("latch", 8'h04, {24'h0, ea[0] ? ~ea[8:1] : ea[8:1]});
		end
		$display("test table done");
	endtask

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence after reset release through the sync stages
	initial
	begin
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		t_reset;
		t_xorl;
		t_xorf;
		t_tst;
		t_tbl(1'b0);
		t_tbl(1'b1);
		give_verdict;
	end
	// Tests need under 500 clocks; allow forty times that
	initial
	begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		give_verdict;
	end
endmodule
`default_nettype wire

// ==== tb/txs_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Program memory array and file register model
// ****************************************************************
module txs_mem_model (
	input  wire logic        clk_in,
	input  wire logic [19:0] pmem_word_addr_in,
	input  wire logic        pmem_rd_in,
	output logic      [15:0] pmem_data_out,
	input  wire logic [11:0] file_addr_in,
	input  wire logic        file_rd_in,
	input  wire logic        file_we_in,
	input  wire logic [7:0]  file_wdata_in,
	output logic      [7:0]  file_rdata_out
);
	logic [7:0]  fmem [0:4095];
	logic [15:0] plast = 16'h0000;
	logic [7:0]  flast = 8'h00;
	// Low byte is word address bits 7:0, high byte their inverse
	function automatic logic [15:0] word_at(input logic [19:0] w);
		return {~w[7:0], w[7:0]};
	endfunction
	// Idle buses show the inverse of the last value, so stale data fails
	assign pmem_data_out = pmem_rd_in ? word_at(pmem_word_addr_in) : ~plast;
	assign file_rdata_out = file_rd_in ? fmem[file_addr_in] : ~flast;
	// Remember driven values and apply file writes
	always @(posedge clk_in)
	begin
		if (pmem_rd_in)
			plast <= pmem_data_out;
		if (file_rd_in)
			flast <= file_rdata_out;
		if (file_we_in)
			fmem[file_addr_in] <= file_wdata_in;
	end
endmodule
`default_nettype wire
